// [common/ssf_pkg.sv]
package ssf_pkg;
   // ----------------------------------------
   // framing
   // ----------------------------------------
   localparam int PAYLOAD_W = 18;
   localparam int FRAME_W = 20;
   localparam int BIT_CNT_W = 5;
   localparam logic [4:0] LAST_BIT = 5'h13;
   localparam logic [4:0] HALF_WORD = 5'h0a;
   localparam logic START_BIT = 1'b1;
   localparam logic STOP_BIT = 1'b0;
   // ----------------------------------------
   // sync pattern and lock
   // ----------------------------------------
   localparam logic [2:0] SYNC_MIN_REF = 3'h6;
   localparam int SYNC_CNT_W = 11;
   localparam logic [10:0] SYNC_WORDS = 11'h402;
   localparam logic [17:0] SYNC_PATTERN = 18'h001ff;
   localparam logic [2:0] LOCK_WORDS = 3'h4;
   localparam logic [2:0] UNLOCK_WORDS = 3'h4;
   localparam logic [3:0] HOLDOFF_WORDS = 4'h9;
   localparam int FIFO_DEPTH = 4;
   typedef enum {ST_HUNT, ST_LOCKED, ST_HOLDOFF} ssf_rx_state_e;
endpackage : ssf_pkg

// [logic/ssf_fifo.sv]
`timescale 1ns/100ps
module ssf_fifo #(
   parameter int W = 18,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // fill side
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] cnt_reg;
   logic [AW:0] cnt_next;
   logic push;
   logic pop;

   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   // ready kept in a flop so the port is registered
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= '0;
         in_ready <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         in_ready <= (cnt_next != DEPTH[AW:0]);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end
endmodule : ssf_fifo

// [logic/ssf_serdes.sv]
`timescale 1ns/100ps
// Contract
// - take one transmit word per reference tick, none during a sync burst
// - frame payload with start one, stop zero
// - twenty serial bits per reference period
// - payload bit zero leaves first
// - fixed load to bit zero latency
// - retime input, find start/stop boundary
// - strip framing, present payload on word clock
// - boost first bit of each run
// - loopback feeds serializer into deserializer
// - reset: word clock low, outputs floated
// - lock after four, drop after four
// - long sync request sends 1026 sync words
// - lock indicator inactive nine words after loss
// - serial outputs floated during loopback
module ssf_serdes
   import ssf_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // transmit parallel side
   input wire logic [PAYLOAD_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic tx_ref_clk,
   input wire logic sync_req,
   // configuration
   input wire logic preemph_sel,
   input wire logic loopback_enable,
   // serial link
   output logic serial_out_pos,
   output logic serial_out_neg,
   output logic serial_oe,
   output logic serial_emph,
   input wire logic serial_in_pos,
   input wire logic serial_in_neg,
   // receive parallel side
   output logic [PAYLOAD_W-1:0] rx_data,
   output logic rx_data_oe,
   output logic rx_word_clk,
   output logic link_locked_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [4:0] pin_s1_reg;
   logic [4:0] pin_s2_reg;
   logic sync_s;
   logic preemph_s;
   logic loop_s;
   logic rx_line;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end else begin
         pin_s1_reg <= {serial_in_neg, serial_in_pos, sync_req, preemph_sel, loopback_enable};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   assign loop_s = pin_s2_reg[0];
   assign preemph_s = pin_s2_reg[1];
   assign sync_s = pin_s2_reg[2];

   // ----------------------------------------
   // transmit word timing
   // ----------------------------------------
   logic [BIT_CNT_W-1:0] tx_cnt_reg;
   logic tx_load;
   logic [PAYLOAD_W-1:0] fifo_data;
   logic fifo_valid;
   logic [PAYLOAD_W-1:0] tx_payload;
   logic [FRAME_W-1:0] tx_shift_reg;
   logic last_bit_reg;
   logic [2:0] sync_hi_reg;
   logic [SYNC_CNT_W-1:0] sync_left_reg;
   logic sync_fire;
   logic sync_active;

   // free divider, one word per 20 bits
   assign tx_load = (tx_cnt_reg == LAST_BIT);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tx_cnt_reg <= '0;
         tx_ref_clk <= 1'b0;
      end else begin
         tx_cnt_reg <= tx_load ? '0 : tx_cnt_reg + 1'b1;
         tx_ref_clk <= (tx_cnt_reg >= HALF_WORD);
      end
   end

   // fifo drained once per tick outside sync bursts; source must hold data while valid
   ssf_fifo #(
      .W(PAYLOAD_W),
      .DEPTH(FIFO_DEPTH),
      .AW(2)
   ) u_tx_fifo (
      .clk(sys_clk),
      .resetn(resetn),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(tx_load && !sync_active)
   );

   // ----------------------------------------
   // sync request
   // ----------------------------------------
   assign sync_active = (sync_left_reg != '0);
   assign sync_fire = tx_load && sync_s && (sync_hi_reg == SYNC_MIN_REF);

   // held past six ticks starts sync burst
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync_hi_reg <= '0;
         sync_left_reg <= '0;
      end else begin
         if (!sync_s) begin
            sync_hi_reg <= '0;
         end else if (tx_load && sync_hi_reg != 3'h7) begin
            sync_hi_reg <= sync_hi_reg + 1'b1;
         end
         if (sync_fire) begin
            sync_left_reg <= SYNC_WORDS;
         end else if (tx_load && sync_active) begin
            sync_left_reg <= sync_left_reg - 1'b1;
         end
      end
   end

   // idle words carry zero payload when the fifo runs dry
   always_comb begin
      tx_payload = '0;
      if (sync_active) begin
         tx_payload = SYNC_PATTERN;
      end else if (fifo_valid) begin
         tx_payload = fifo_data;
      end
   end

   // free divider keeps load to bit zero delay fixed
   // stop on top, start at bit zero; shift right, low first
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tx_shift_reg <= '0;
         last_bit_reg <= 1'b0;
      end else begin
         last_bit_reg <= tx_shift_reg[0];
         if (tx_load) begin
            tx_shift_reg <= {STOP_BIT, tx_payload, START_BIT};
         end else begin
            tx_shift_reg <= {1'b0, tx_shift_reg[FRAME_W-1:1]};
         end
      end
   end

   // ----------------------------------------
   // serial driver
   // ----------------------------------------
   // floated in reset; floated in loopback
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         serial_out_pos <= 1'b0;
         serial_out_neg <= 1'b1;
         serial_oe <= 1'b0;
         serial_emph <= 1'b0;
      end else begin
         serial_out_pos <= tx_shift_reg[0];
         serial_out_neg <= !tx_shift_reg[0];
         serial_oe <= !loop_s;
         // boost on a change of level
         serial_emph <= preemph_s && (tx_shift_reg[0] != last_bit_reg);
      end
   end

   // ----------------------------------------
   // receive framer
   // ----------------------------------------
   logic [FRAME_W-1:0] rx_sr_reg;
   logic [BIT_CNT_W-1:0] rx_cnt_reg;
   logic rx_eval;
   logic rx_ok;
   logic [2:0] good_cnt_reg;
   logic [2:0] bad_cnt_reg;
   logic [3:0] hold_cnt_reg;
   ssf_rx_state_e rx_state_reg;
   logic rx_locked;

   assign rx_line = loop_s ? last_bit_reg : (pin_s2_reg[3] && !pin_s2_reg[4]);
   assign rx_eval = (rx_cnt_reg == LAST_BIT);
   assign rx_ok = (rx_sr_reg[0] == START_BIT) && (rx_sr_reg[FRAME_W-1] == STOP_BIT);
   assign rx_locked = (rx_state_reg == ST_LOCKED);

   // retime and slide one bit per try while hunting
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_sr_reg <= '0;
         rx_cnt_reg <= '0;
      end else begin
         rx_sr_reg <= {rx_line, rx_sr_reg[FRAME_W-1:1]};
         if (rx_eval && !rx_ok && rx_state_reg == ST_HUNT) begin
            rx_cnt_reg <= LAST_BIT;
         end else begin
            rx_cnt_reg <= rx_eval ? '0 : rx_cnt_reg + 1'b1;
         end
      end
   end

   // lock state; hold-off before hunting again
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_state_reg <= ST_HUNT;
         good_cnt_reg <= '0;
         bad_cnt_reg <= '0;
         hold_cnt_reg <= '0;
      end else if (rx_eval) begin
         case (rx_state_reg)
            ST_HUNT: begin
               good_cnt_reg <= rx_ok ? good_cnt_reg + 1'b1 : '0;
               if (rx_ok && good_cnt_reg == LOCK_WORDS - 3'h1) begin
                  rx_state_reg <= ST_LOCKED;
                  good_cnt_reg <= '0;
                  bad_cnt_reg <= '0;
               end
            end
            ST_LOCKED: begin
               bad_cnt_reg <= rx_ok ? '0 : bad_cnt_reg + 1'b1;
               if (!rx_ok && bad_cnt_reg == UNLOCK_WORDS - 3'h1) begin
                  rx_state_reg <= ST_HOLDOFF;
                  hold_cnt_reg <= '0;
               end
            end
            default: begin
               hold_cnt_reg <= hold_cnt_reg + 1'b1;
               if (hold_cnt_reg == HOLDOFF_WORDS - 4'h1) begin
                  rx_state_reg <= ST_HUNT;
                  good_cnt_reg <= '0;
               end
            end
         endcase
      end
   end

   // payload sits between framing bits; once per word
   // word clock low and bus floated until locked
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_data <= '0;
         rx_data_oe <= 1'b0;
         rx_word_clk <= 1'b0;
         link_locked_n <= 1'b1;
      end else begin
         if (rx_eval && rx_locked) begin
            rx_data <= rx_sr_reg[FRAME_W-2:1];
         end
         rx_data_oe <= rx_locked;
         rx_word_clk <= rx_locked && (rx_cnt_reg < HALF_WORD);
         link_locked_n <= !rx_locked;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_frame_bits: assert property (tx_load |=> tx_shift_reg[0] && !tx_shift_reg[FRAME_W-1])
      else $error("frame bits wrong");
   a_lsb_first: assert property (tx_load |=> ##1 tx_shift_reg[0] == $past(tx_payload[0], 2))
      else $error("payload bit zero not first");
   a_word_period: assert property (tx_load |-> ##20 tx_load)
      else $error("word period not twenty bits");
   a_loop_float: assert property (loop_s |=> !serial_oe)
      else $error("serial driven in loopback");
   a_emph_run: assert property ((preemph_s && tx_shift_reg[0] != last_bit_reg) |=> serial_emph)
      else $error("run start not boosted");
   a_sync_words: assert property ((tx_load && sync_active) |=> tx_shift_reg[FRAME_W-2:1] == SYNC_PATTERN)
      else $error("sync pattern not sent");
   a_lock_four: assert property ($rose(rx_locked) |-> $past(good_cnt_reg) == LOCK_WORDS - 3'h1)
      else $error("locked too early");
   a_hold_nine: assert property ($fell(rx_locked) |-> (!rx_locked throughout ##179 1'b1))
      else $error("relocked within nine words");
   a_clk_low: assert property (!rx_locked |=> !rx_word_clk && !rx_data_oe)
      else $error("word clock running unlocked");
   a_data_stable: assert property ($rose(rx_word_clk) |-> $stable(rx_data))
      else $error("data moved at word clock edge");
endmodule : ssf_serdes

// [verif/ssf_link_model.sv]
`timescale 1ns/100ps
module ssf_link_model
   import ssf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // word source
   input wire logic [PAYLOAD_W-1:0] word,
   input wire logic bad,
   output logic take,
   // serial pair
   output logic ser_pos,
   output logic ser_neg
);
   logic [FRAME_W-1:0] sh_reg;
   logic [4:0] cnt_reg;
   assign take = resetn && cnt_reg == LAST_BIT;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= '0;
         sh_reg <= '0;
      end else begin
         cnt_reg <= take ? 5'h00 : cnt_reg + 5'h01;
         sh_reg <= take ? {STOP_BIT, word, START_BIT} : sh_reg >> 1;
      end
   end
   // all ones on demand: stop bit never seen
   assign ser_pos = bad | sh_reg[0];
   assign ser_neg = ~ser_pos;
endmodule : ssf_link_model

// [verif/start_stop_serdes_framing_test.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
$display("mismatch %s expected %h seen %h", nm, e, g); end end
module start_stop_serdes_framing_test;
   import ssf_pkg::*;
   logic sys_clk = 0;
   logic resetn = 0;
   logic [PAYLOAD_W-1:0] tx_data = '0, rx_data, p_word = '0, w;
   logic tx_valid = 0, tx_ready, tx_ref_clk, sync_req = 0, preemph_sel = 1;
   logic loopback_enable = 0, serial_out_pos, serial_out_neg, serial_oe, serial_emph;
   logic s_pos, s_neg, rx_data_oe, rx_word_clk, link_locked_n, p_bad = 1, p_take;
   logic prev_pos = 0, emph_on = 0, prev_wclk = 0;
   int err_count = 0, samples_checked = 0, nsync = 0, k, lat = 0;
   logic [PAYLOAD_W-1:0] exp_w;
   logic [31:0] rng = 32'hb222;
   logic [PAYLOAD_W-1:0] exp_q[$];
   logic [FRAME_W-1:0] win = '0;
   always #50 sys_clk = ~sys_clk;
   ssf_serdes DUT (.sys_clk(sys_clk), .resetn(resetn), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_ref_clk(tx_ref_clk),
      .sync_req(sync_req), .preemph_sel(preemph_sel), .loopback_enable(loopback_enable),
      .serial_out_pos(serial_out_pos), .serial_out_neg(serial_out_neg),
      .serial_oe(serial_oe), .serial_emph(serial_emph), .serial_in_pos(s_pos),
      .serial_in_neg(s_neg), .rx_data(rx_data), .rx_data_oe(rx_data_oe),
      .rx_word_clk(rx_word_clk), .link_locked_n(link_locked_n));
   ssf_link_model u_link (.clk(sys_clk), .resetn(resetn), .word(p_word), .bad(p_bad),
      .take(p_take), .ser_pos(s_pos), .ser_neg(s_neg));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic summarize();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize
   task automatic tick_or_fail(input int lim);
      @(posedge sys_clk);
      k++;
      if (k > lim) begin
         err_count++;
         $display("mismatch wait expected done seen timeout");
         summarize();
      end
   endtask : tick_or_fail
   task automatic wait_lock(input logic lvl);
      k = 0;
      while (link_locked_n !== lvl) tick_or_fail(3000);
   endtask : wait_lock
   task automatic send_tx(input logic note);
      rng = xs(rng);
      w = rng[17:0] | 18'h1;
      tx_data <= w;
      tx_valid <= 1;
      k = 0;
      do tick_or_fail(200); while (tx_ready !== 1);
      // valid stays high between back to back calls; the next call replaces the data before the next edge, so no word is pushed twice
      if (note) exp_q.push_back(w);
   endtask : send_tx
   // ----------------------------------------
   // output watcher
   // ----------------------------------------
   always @(posedge sys_clk) begin
      win <= {serial_out_pos, win[FRAME_W-1:1]};
      prev_pos <= serial_out_pos;
      prev_wclk <= rx_word_clk;
      if (win == {STOP_BIT, SYNC_PATTERN, START_BIT}) nsync++;
      if (emph_on && serial_oe) begin
         `CHK("emph", preemph_sel && serial_out_pos != prev_pos, serial_emph)
         `CHK("serial_out_neg", ~serial_out_pos, serial_out_neg)
      end
      // zero payload is idle fill, never a noted word
      if (rx_word_clk && !prev_wclk && exp_q.size() > 0 && rx_data !== '0) begin
         exp_w = exp_q.pop_front();
         `CHK("rx_data", exp_w, rx_data)
         `CHK("rx_data_oe", 1'b1, rx_data_oe)
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge sys_clk);
      `CHK("oe in reset", 1'b0, serial_oe)
      `CHK("wclk in reset", 1'b0, rx_word_clk)
      `CHK("lock in reset", 1'b1, link_locked_n)
      repeat (4) @(posedge sys_clk);
      resetn <= 1;
      loopback_enable <= 1;
      @(posedge sys_clk);
      wait_lock(0);
      `CHK("oe loopback", 1'b0, serial_oe)
      // back to back: fifo fills and refuses
      repeat (10) send_tx(1);
      tx_valid <= 0;
      k = 0;
      while (exp_q.size() > 0) tick_or_fail(800);
      loopback_enable <= 0;
      wait_lock(1);
      repeat (60) @(posedge sys_clk);
      p_bad <= 0;
      k = 0;
      while (link_locked_n !== 0) tick_or_fail(3000);
      `CHK("holdoff", 1'b1, k >= 180)
      `CHK("oe normal", 1'b1, serial_oe)
      emph_on <= 1;
      for (int i = 0; i < 6; i++) begin
         k = 0;
         do tick_or_fail(40); while (p_take !== 1);
         rng = xs(rng);
         p_word <= rng[17:0] | 18'h1;
         exp_q.push_back(rng[17:0] | 18'h1);
      end
      k = 0;
      do tick_or_fail(40); while (p_take !== 1);
      p_word <= '0;
      // offer each word at the same reference clock phase so the delay must repeat
      for (int i = 0; i < 3; i++) begin
         k = 0;
         while (tx_ref_clk !== 1'b0) tick_or_fail(40);
         while (tx_ref_clk !== 1'b1) tick_or_fail(40);
         send_tx(0);
         tx_valid <= 0;
         k = 0;
         while (win !== {STOP_BIT, w, START_BIT}) tick_or_fail(120);
         if (i == 0) lat = k;
         `CHK("latency", lat, k)
      end
      `CHK("rx drained", 0, exp_q.size())
      // emphasis off for the sync burst: no boost expected
      emph_on <= 0;
      preemph_sel <= 0;
      repeat (4) @(posedge sys_clk);
      emph_on <= 1;
      nsync = 0;
      sync_req <= 1;
      repeat (200) @(posedge sys_clk);
      sync_req <= 0;
      repeat (21500) @(posedge sys_clk);
      `CHK("sync words", 1026, nsync)
      summarize();
   end
endmodule : start_stop_serdes_framing_test
